// file: rtl/loss_timer.sv
// Purpose: counts tenth steps while run_i is high, in the wait after link loss
// Assumes: tick_i from tenth_tick, cleared together with run_i
// Notes: saturates at the largest step count
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
module loss_timer (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [7:0] delay_i,
  output logic expired_o
);
  logic [7:0] cnt_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !run_i) begin
      cnt_r <= 8'h00;
    end else if (tick_i && cnt_r != `OFS_STEP_MAX) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // zero delay expires at once [R5]
  assign expired_o = run_i && (cnt_r >= delay_i);
endmodule
`default_nettype wire

// file: rtl/ofs_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM byte addresses, one word per register
// Notes: included by every module file of the output port and by the testbench
`ifndef OFS_CONSTS_SVH
`define OFS_CONSTS_SVH

`define OFS_ADDR_W 6
`define OFS_ADDR_IMAGE 6'h00
`define OFS_ADDR_KIND 6'h04
`define OFS_ADDR_PATTERN 6'h08
`define OFS_ADDR_DELAY 6'h0C
`define OFS_ADDR_COMMIT 6'h10
`define OFS_ADDR_STATUS 6'h14
`define OFS_ADDR_IRQ_STS 6'h18
`define OFS_ADDR_IRQ_CLR 6'h1C
`define OFS_ADDR_IRQ_EN 6'h20

`define OFS_COMMIT_BIT 0
`define OFS_EVT_W 4
`define OFS_EVT_SAFE 0
`define OFS_EVT_LOST 1
`define OFS_EVT_RESUME 2
`define OFS_EVT_COMMIT 3

`define OFS_RST_IMAGE 8'h00
`define OFS_RST_KIND 8'h01
`define OFS_RST_PATTERN 8'h00
`define OFS_RST_DELAY 8'h00
`define OFS_STEP_MAX 8'hFF

`define OFS_CLK_PERIOD_NS 100
`define OFS_TENTH_NS 100000000
`define OFS_TENTH_CYC (`OFS_TENTH_NS / `OFS_CLK_PERIOD_NS)

`endif

// file: rtl/ofs_pkg.sv
// Purpose: types shared by the output port files
// Assumes: nothing
// Notes: one-hot mode codes, fail-safe kind codes
package ofs_pkg;

  typedef logic [7:0] point_t;

  typedef enum logic [2:0] {
    ST_HOST = 3'b001,
    ST_WAIT = 3'b010,
    ST_SAFE = 3'b100
  } mode_e;

  typedef enum logic [7:0] {
    KIND_OFF = 8'h01,
    KIND_PATTERN = 8'h02,
    KIND_HOLD = 8'h03
  } kind_e;

endpackage

// file: rtl/output_port_failsafe.sv
// Purpose: eight-point output port with staged fail-safe unit
// Assumes: host_valid_i pulses per valid host message, comm_lost_i level
// Notes: Avalon-MM slave, one wait state per access
// Notes on behaviour
// R1 - after link loss and the set delay, outputs enter fail-safe.
// R2 - kind 1 all off, kind 2 stored pattern, kind 3 hold last.
// R3 - stored pattern drives outputs only under kind 2.
// R4 - pattern bit n sets point n on or off in fail-safe.
// R5 - delay counts tenth seconds from loss, up to 25.5 s; zero is immediate.
// R6 - written kind stays staged until commit.
// R7 - written pattern stays staged until commit.
// R8 - commit copies kind, delay, pattern into active set, then self-clears.
// R9 - host leaves commit clear; writing zero does nothing.
// R10 - host reads and writes the eight-point image, bit n drives point n.
// R11 - valid host traffic restarts the delay and ends fail-safe.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
module output_port_failsafe #(
  parameter int unsigned TENTH_CYC = `OFS_TENTH_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [`OFS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic host_valid_i,
  input wire logic comm_lost_i,
  output ofs_pkg::point_t point_o,
  output logic failsafe_o,
  output logic irq_o
);
  import ofs_pkg::*;

  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  mode_e st_r;
  mode_e st_nxt;
  point_t image_r;
  point_t stg_pat_r;
  point_t act_pat_r;
  point_t point_r;
  point_t point_nxt;
  logic [7:0] stg_kind_r;
  logic [7:0] act_kind_r;
  logic [7:0] stg_delay_r;
  logic [7:0] act_delay_r;
  logic [`OFS_EVT_W-1:0] irq_sts_r;
  logic [`OFS_EVT_W-1:0] irq_en_r;
  logic [`OFS_EVT_W-1:0] evt;
  logic [`OFS_EVT_W-1:0] clr_mask;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic lo_wr;
  logic img_wr;
  logic commit_go;
  logic comm_seen;
  logic run;
  logic tick;
  logic expired;

  // bus handshake, one wait state
  assign acc = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = acc & ~ack_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc & ~ack_r;
    end
  end

  assign wr_go = avs_write_i & ack_r;
  assign rd_go = avs_read_i & ~ack_r;
  assign lo_wr = wr_go & avs_byteenable_i[0];
  assign img_wr = lo_wr && (avs_address_i == `OFS_ADDR_IMAGE);
  // only a one in the commit bit acts [R8] [R9]
  assign commit_go = lo_wr && (avs_address_i == `OFS_ADDR_COMMIT)
                     && avs_writedata_i[`OFS_COMMIT_BIT];
  // image writes count as host traffic [R11]
  assign comm_seen = host_valid_i | img_wr;

  // read mux, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `OFS_ADDR_IMAGE: begin
        rd_mux[7:0] = image_r; // [R10]
      end
      `OFS_ADDR_KIND: begin
        rd_mux[7:0] = stg_kind_r;
      end
      `OFS_ADDR_PATTERN: begin
        rd_mux[7:0] = stg_pat_r;
      end
      `OFS_ADDR_DELAY: begin
        rd_mux[7:0] = stg_delay_r;
      end
      `OFS_ADDR_STATUS: begin
        rd_mux[0] = (st_r == ST_SAFE);
        rd_mux[1] = (st_r == ST_WAIT);
        rd_mux[15:8] = act_pat_r;
        rd_mux[23:16] = act_delay_r;
        rd_mux[31:24] = act_kind_r;
      end
      `OFS_ADDR_IRQ_STS: begin
        rd_mux[`OFS_EVT_W-1:0] = irq_sts_r;
      end
      `OFS_ADDR_IRQ_EN: begin
        rd_mux[`OFS_EVT_W-1:0] = irq_en_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_r <= rd_mux;
    end
  end

  assign avs_readdata_o = rdata_r;

  // output image, host owned
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      image_r <= `OFS_RST_IMAGE;
    end else if (img_wr) begin
      image_r <= avs_writedata_i[7:0]; // [R10]
    end
  end

  // staged configuration
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      stg_kind_r <= `OFS_RST_KIND;
      stg_pat_r <= `OFS_RST_PATTERN;
      stg_delay_r <= `OFS_RST_DELAY;
    end else if (lo_wr) begin
      case (avs_address_i)
        `OFS_ADDR_KIND: begin
          stg_kind_r <= avs_writedata_i[7:0]; // [R6]
        end
        `OFS_ADDR_PATTERN: begin
          stg_pat_r <= avs_writedata_i[7:0]; // [R7]
        end
        `OFS_ADDR_DELAY: begin
          stg_delay_r <= avs_writedata_i[7:0]; // [R5]
        end
        default: begin
          stg_kind_r <= stg_kind_r;
        end
      endcase
    end
  end

  // active configuration, loaded only by commit
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      act_kind_r <= `OFS_RST_KIND;
      act_pat_r <= `OFS_RST_PATTERN;
      act_delay_r <= `OFS_RST_DELAY;
    end else if (commit_go) begin
      act_kind_r <= stg_kind_r; // [R6] [R8]
      act_pat_r <= stg_pat_r; // [R7] [R8]
      act_delay_r <= stg_delay_r; // [R8]
    end
  end

  // mode machine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_HOST: begin
        if (comm_lost_i && !comm_seen) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (comm_seen || !comm_lost_i) begin
          st_nxt = ST_HOST; // [R11]
        end else if (expired) begin
          st_nxt = ST_SAFE; // [R1]
        end
      end
      ST_SAFE: begin
        if (comm_seen) begin
          st_nxt = ST_HOST; // [R11]
        end
      end
      default: begin
        st_nxt = ST_HOST;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_r <= ST_HOST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // delay restarts whenever waiting ends [R5] [R11]
  assign run = (st_r == ST_WAIT);

  tenth_tick #(
    .DIV(TENTH_CYC)
  ) u_tick (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clr_i(!run),
    .tick_o(tick)
  );

  loss_timer u_timer (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .run_i(run),
    .tick_i(tick),
    .delay_i(act_delay_r),
    .expired_o(expired)
  );

  // per-point output select
  for (genvar i = 0; i < 8; i++) begin : g_point
    assign point_nxt[i] = (st_r != ST_SAFE) ? image_r[i] :
                          (act_kind_r == KIND_OFF) ? 1'b0 : // [R2]
                          (act_kind_r == KIND_PATTERN) ? act_pat_r[i] : // [R3] [R4]
                          point_r[i]; // [R2]
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      point_r <= `OFS_RST_IMAGE;
    end else begin
      point_r <= point_nxt;
    end
  end

  assign point_o = point_r;
  assign failsafe_o = (st_r == ST_SAFE);

  // interrupt events
  always_comb begin
    evt = '0;
    evt[`OFS_EVT_SAFE] = (st_r == ST_WAIT) && (st_nxt == ST_SAFE);
    evt[`OFS_EVT_LOST] = (st_r == ST_HOST) && (st_nxt == ST_WAIT);
    evt[`OFS_EVT_RESUME] = (st_r == ST_SAFE) && (st_nxt == ST_HOST);
    evt[`OFS_EVT_COMMIT] = commit_go;
  end

  assign clr_mask = (lo_wr && avs_address_i == `OFS_ADDR_IRQ_CLR) ?
                    avs_writedata_i[`OFS_EVT_W-1:0] : '0;

  // set wins over clear
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_sts_r <= '0;
    end else begin
      irq_sts_r <= (irq_sts_r & ~clr_mask) | evt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_en_r <= '0;
    end else if (lo_wr && avs_address_i == `OFS_ADDR_IRQ_EN) begin
      irq_en_r <= avs_writedata_i[`OFS_EVT_W-1:0];
    end
  end

  assign irq_o = |(irq_sts_r & irq_en_r);

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  a_safe_entry: assert property ( // [R1]
    st_r == ST_WAIT && expired && comm_lost_i && !comm_seen
    |=> st_r == ST_SAFE && failsafe_o)
    else $error("fail-safe not entered after delay");

  a_kind_off: assert property ( // [R2]
    st_r == ST_SAFE && act_kind_r == KIND_OFF && !comm_seen
    |=> point_o == 8'h00)
    else $error("kind off did not clear outputs");

  a_kind_hold: assert property ( // [R2]
    st_r == ST_SAFE && act_kind_r == KIND_HOLD && !comm_seen
    |=> $stable(point_o))
    else $error("kind hold changed outputs");

  a_pattern_drive: assert property ( // [R3]
    st_r == ST_SAFE && act_kind_r == KIND_PATTERN && !comm_seen
    |=> point_o == $past(act_pat_r))
    else $error("pattern not driven under kind 2");

  a_zero_delay: assert property ( // [R5]
    $rose(st_r == ST_WAIT) && act_delay_r == 8'h00
    && comm_lost_i && !comm_seen
    |=> st_r == ST_SAFE)
    else $error("zero delay did not engage at once");

  a_kind_staged: assert property ( // [R6]
    !commit_go |=> $stable(act_kind_r))
    else $error("active kind moved without commit");

  a_pattern_staged: assert property ( // [R7]
    !commit_go |=> $stable(act_pat_r) && $stable(act_delay_r))
    else $error("active pattern moved without commit");

  a_commit_copy: assert property ( // [R8]
    commit_go |=> act_kind_r == $past(stg_kind_r)
    && act_pat_r == $past(stg_pat_r)
    && act_delay_r == $past(stg_delay_r))
    else $error("commit did not copy staged set");

  a_image_drive: assert property ( // [R10]
    img_wr |=> ##1 point_o == $past(avs_writedata_i[7:0], 2))
    else $error("image write did not reach outputs");

  a_comm_restore: assert property ( // [R11]
    comm_seen |=> st_r == ST_HOST && !run)
    else $error("host traffic did not restore control");

  c_safe_off: cover property (
    st_r == ST_WAIT ##1 st_r == ST_SAFE && act_kind_r == KIND_OFF);

  c_safe_pattern: cover property (
    st_r == ST_SAFE && act_kind_r == KIND_PATTERN ##1 point_o == act_pat_r);

  c_safe_hold: cover property (
    st_r == ST_SAFE && act_kind_r == KIND_HOLD && point_o != 8'h00);

  c_resume: cover property (
    st_r == ST_SAFE ##1 st_r == ST_HOST);

endmodule
`default_nettype wire

// file: rtl/tenth_tick.sv
// Purpose: one-cycle enable every tenth of a second
// Assumes: mclk_i at 10 MHz
// Notes: clr_i restarts the phase so the first tick is a full step away
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
module tenth_tick #(
  parameter int unsigned DIV = `OFS_TENTH_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || clr_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r == W'(DIV - 1)) begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/host_link_model.sv
// Purpose: host side of the link, loses and restores contact
// Assumes: one message pulse per ping
// Notes: signals change by non-blocking assignment after an edge
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input wire logic mclk_i,
  output logic host_valid_o,
  output logic comm_lost_o
);
  initial begin
    host_valid_o = 1'b0;
    comm_lost_o = 1'b0;
  end
  // link drops and stays down
  task automatic lose();
    @(posedge mclk_i);
    comm_lost_o <= 1'b1;
  endtask
  // link layer recovers with no message yet
  task automatic restore();
    @(posedge mclk_i);
    comm_lost_o <= 1'b0;
  endtask
  // link back up with one valid message
  task automatic ping();
    @(posedge mclk_i);
    comm_lost_o <= 1'b0;
    host_valid_o <= 1'b1;
    @(posedge mclk_i);
    host_valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the output port
// Assumes: TENTH_CYC of 10 cycles
// Notes: host link driven through host_link_model
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import ofs_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [`OFS_ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic host_valid_i;
  logic comm_lost_i;
  point_t point_o;
  logic failsafe_o;
  logic irq_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] q;

  always #50 mclk_i = ~mclk_i;

  output_port_failsafe #(.TENTH_CYC(10)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .host_valid_i(host_valid_i), .comm_lost_i(comm_lost_i),
    .point_o(point_o), .failsafe_o(failsafe_o), .irq_o(irq_o)
  );
  host_link_model host (
    .mclk_i(mclk_i), .host_valid_o(host_valid_i), .comm_lost_o(comm_lost_i)
  );

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= d;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic t_regs();
    rd(`OFS_ADDR_IMAGE);
    `CHK(q, 32'h0)
    rd(`OFS_ADDR_KIND);
    `CHK(q, 32'h1)
    rd(6'h3C);
    `CHK(q, 32'h0)
    @(posedge mclk_i);
    avs_byteenable_i <= 4'hE;
    wr(`OFS_ADDR_IMAGE, 32'hFF);
    avs_byteenable_i <= 4'hF;
    settle();
    `CHK(point_o, 8'h00)
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_ADDR_IMAGE, 32'h1 << i);
      settle();
      `CHK(point_o, 8'(1 << i))
    end
    wr(`OFS_ADDR_IMAGE, 32'hFF);
    rd(`OFS_ADDR_IMAGE);
    `CHK(q, 32'hFF)
    $display("test regs done");
  endtask

  task automatic t_stage();
    wr(`OFS_ADDR_KIND, 32'h2);
    wr(`OFS_ADDR_PATTERN, 32'hA5);
    rd(`OFS_ADDR_STATUS);
    `CHK(q[31:8], 24'h010000)
    wr(`OFS_ADDR_COMMIT, 32'h0);
    rd(`OFS_ADDR_STATUS);
    `CHK(q[31:8], 24'h010000)
    wr(`OFS_ADDR_COMMIT, 32'h1);
    rd(`OFS_ADDR_STATUS);
    `CHK(q[31:8], 24'h0200A5)
    rd(`OFS_ADDR_COMMIT);
    `CHK(q, 32'h0)
    $display("test stage done");
  endtask

  task automatic t_kinds();
    point_t exp[3];
    exp = '{8'h00, 8'hA5, 8'h3C};
    wr(`OFS_ADDR_IMAGE, 32'h3C);
    for (int k = 1; k < 4; k++) begin
      wr(`OFS_ADDR_KIND, 32'(k));
      wr(`OFS_ADDR_COMMIT, 32'h1);
      host.lose();
      repeat (6) @(posedge mclk_i);
      `CHK(failsafe_o, 1'b1)
      `CHK(point_o, exp[k-1])
      rd(`OFS_ADDR_STATUS);
      `CHK(q[1:0], 2'b01)
      host.ping();
      repeat (4) @(posedge mclk_i);
      `CHK(failsafe_o, 1'b0)
      `CHK(point_o, 8'h3C)
    end
    $display("test kinds done");
  endtask

  task automatic t_delay();
    wr(`OFS_ADDR_DELAY, 32'h2);
    wr(`OFS_ADDR_COMMIT, 32'h1);
    host.lose();
    repeat (10) @(posedge mclk_i);
    host.ping();
    host.lose();
    repeat (18) @(posedge mclk_i);
    `CHK(failsafe_o, 1'b0)
    rd(`OFS_ADDR_STATUS);
    `CHK(q[1:0], 2'b10)
    repeat (6) if (failsafe_o !== 1'b1) @(posedge mclk_i);
    `CHK(failsafe_o, 1'b1)
    host.ping();
    host.lose();
    repeat (5) @(posedge mclk_i);
    host.restore();
    repeat (30) @(posedge mclk_i);
    `CHK(failsafe_o, 1'b0)
    wr(`OFS_ADDR_DELAY, 32'hFF);
    wr(`OFS_ADDR_COMMIT, 32'h1);
    rd(`OFS_ADDR_STATUS);
    `CHK(q[23:16], 8'hFF)
    $display("test delay done");
  endtask

  task automatic t_irq();
    rd(`OFS_ADDR_IRQ_STS);
    `CHK(q[3:0], 4'hF)
    wr(`OFS_ADDR_IRQ_EN, 32'h0);
    wr(`OFS_ADDR_IRQ_CLR, 32'hF);
    settle();
    `CHK(irq_o, 1'b0)
    wr(`OFS_ADDR_COMMIT, 32'h1);
    settle();
    `CHK(irq_o, 1'b0)
    rd(`OFS_ADDR_IRQ_STS);
    `CHK(q[3:0], 4'h8)
    wr(`OFS_ADDR_IRQ_EN, 32'h8);
    settle();
    `CHK(irq_o, 1'b1)
    wr(`OFS_ADDR_IRQ_CLR, 32'h8);
    settle();
    `CHK(irq_o, 1'b0)
    $display("test irq done");
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_stage();
    t_kinds();
    t_delay();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
